// ---- src/nvm_resp_params.svh ----
`ifndef NVM_RESP_PARAMS_SVH
`define NVM_RESP_PARAMS_SVH
// Minimum execution times in nanoseconds.
`define BLOCK_WRITE_EXEC_TIME_4_NS 4660000
`define BLOCK_WRITE_EXEC_TIME_256_NS 4700000
`define OTHER_WRITE_EXEC_TIME_4_NS 6670000
`define OTHER_WRITE_EXEC_TIME_256_NS 6700000
`define CLK_PERIOD_NS 10
// Carrier-period figures of the response slot.
`define NOMINAL_FIRST_RESPONSE_DELAY_FC 4352
`define RESPONSE_SLOT_STEP_FC 4096
`define RESPONSE_TOLERANCE_FC 32
`define BYTE_BITS 8
`endif

// ---- src/nvm_resp_pkg.sv ----
package nvm_resp_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b10
  } resp_state_type;
  typedef struct packed {
    logic block_kind;
    logic coding_256;
    logic option_flag;
  } write_req_type;
endpackage

// ---- src/nvm_write_response_timing.sv ----
`timescale 1ns/10ps
`include "nvm_resp_params.svh"
// Behaviour
// - A byte is eight bits b1 to b8, b8 the most significant, as on answer_byte_o.
// - Block-write and key-change commands wait at least 4.66 ms (1-of-4) or 4.7 ms (1-of-256).
// - Other writing commands wait at least 6.67 ms (1-of-4) or 6.7 ms (1-of-256).
// - Option flag clear answers in a standard slot, set answers after the next reader EOF.
// - Slot answers start 4352 plus a multiple of 4096 carrier periods after the EOF edge.
module nvm_write_response_timing
  import nvm_resp_pkg::*;
#(
  parameter int BLOCK_4_CYC = (`BLOCK_WRITE_EXEC_TIME_4_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int BLOCK_256_CYC =
    (`BLOCK_WRITE_EXEC_TIME_256_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int OTHER_4_CYC = (`OTHER_WRITE_EXEC_TIME_4_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int OTHER_256_CYC =
    (`OTHER_WRITE_EXEC_TIME_256_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int FC_W = 20
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic carrier_clk_i,
  input wire logic eof_i,
  input wire logic start_i,
  input wire write_req_type req_i,
  input wire logic [7:0] answer_byte_i,
  output logic busy_o,
  output logic answer_start_o,
  output logic [7:0] answer_byte_o
);
  localparam logic [FC_W-1:0] T1_FC = FC_W'(`NOMINAL_FIRST_RESPONSE_DELAY_FC);
  localparam logic [FC_W-1:0] STEP_FC = FC_W'(`RESPONSE_SLOT_STEP_FC);

  logic [1:0] fc_sync_r, fc_sync_nxt;
  logic [1:0] eof_sync_r, eof_sync_nxt;
  logic fc_prev_r, fc_prev_nxt;
  logic eof_prev_r, eof_prev_nxt;
  logic fc_edge;
  logic eof_rise;

  // Both link inputs come from the field side, so two stages stand before any logic reads them.
  always_comb begin
    fc_sync_nxt = {fc_sync_r[0], carrier_clk_i};
    eof_sync_nxt = {eof_sync_r[0], eof_i};
    fc_prev_nxt = fc_sync_r[1];
    eof_prev_nxt = eof_sync_r[1];
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fc_sync_r <= 2'b00;
      eof_sync_r <= 2'b00;
      fc_prev_r <= 1'b0;
      eof_prev_r <= 1'b0;
    end else begin
      fc_sync_r <= fc_sync_nxt;
      eof_sync_r <= eof_sync_nxt;
      fc_prev_r <= fc_prev_nxt;
      eof_prev_r <= eof_prev_nxt;
    end
  end

  // Carrier edges are found by oversampling; the tolerance of 32 periods absorbs the jitter.
  // The system clock must run well above twice the carrier, or carrier edges are lost.
  assign fc_edge = fc_sync_r[1] & ~fc_prev_r;
  assign eof_rise = eof_sync_r[1] & ~eof_prev_r;

  resp_state_type state_r, state_nxt;
  logic [31:0] exec_cnt_r, exec_cnt_nxt;
  logic [FC_W-1:0] fc_cnt_r, fc_cnt_nxt;
  logic opt_r, opt_nxt;
  logic busy_r, busy_nxt;
  logic start_r, start_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic take_req;
  logic exec_done;
  logic slot_hit;
  logic answer_now;

  // A request is taken only while idle; one that arrives during a write is dropped unseen.
  assign take_req = (state_r == ST_IDLE) && start_i;
  assign exec_done = (state_r == ST_EXEC) && (exec_cnt_r <= 32'd1);

  always_comb begin
    exec_cnt_nxt = exec_cnt_r;
    if (take_req) begin
      if (req_i.block_kind) begin
        exec_cnt_nxt = req_i.coding_256 ? 32'(BLOCK_256_CYC) : 32'(BLOCK_4_CYC);
      end else begin
        exec_cnt_nxt = req_i.coding_256 ? 32'(OTHER_256_CYC) : 32'(OTHER_4_CYC);
      end
    end else if (state_r == ST_EXEC) begin
      exec_cnt_nxt = exec_cnt_r - 32'd1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      exec_cnt_r <= 32'd0;
    end else begin
      exec_cnt_r <= exec_cnt_nxt;
    end
  end

  // Counting restarts at the taken request, which stands in for the request's EOF edge.
  // The counter may wrap while a flag-set answer waits, which does not matter there.
  always_comb begin
    fc_cnt_nxt = fc_cnt_r;
    if (take_req) begin
      fc_cnt_nxt = '0;
    end else if (fc_edge) begin
      fc_cnt_nxt = fc_cnt_r + FC_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      fc_cnt_r <= '0;
    end else begin
      fc_cnt_r <= fc_cnt_nxt;
    end
  end

  // Slot instants are T1 then every STEP carrier periods after the request EOF.
  assign slot_hit = fc_edge && (fc_cnt_r + FC_W'(1) >= T1_FC) &&
                    ((fc_cnt_r + FC_W'(1) - T1_FC) % STEP_FC == '0);
  assign answer_now = (state_r == ST_WAIT) &&
                      ((opt_r && eof_rise) || (!opt_r && slot_hit));

  always_comb begin
    state_nxt = state_r;
    opt_nxt = opt_r;
    busy_nxt = busy_r;
    start_nxt = 1'b0;
    byte_nxt = byte_r;
    unique case (state_r)
      ST_IDLE: begin
        if (take_req) begin
          state_nxt = ST_EXEC;
          busy_nxt = 1'b1;
          opt_nxt = req_i.option_flag;
          byte_nxt = answer_byte_i;
        end
      end
      ST_EXEC: begin
        if (exec_done) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // A reader mark seen while the write still runs is lost, so the next one is awaited.
        if (answer_now) begin
          state_nxt = ST_IDLE;
          start_nxt = 1'b1;
          busy_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        busy_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      opt_r <= 1'b0;
      busy_r <= 1'b0;
      start_r <= 1'b0;
      byte_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      opt_r <= opt_nxt;
      busy_r <= busy_nxt;
      start_r <= start_nxt;
      byte_r <= byte_nxt;
    end
  end

  assign busy_o = busy_r;
  assign answer_start_o = start_r;
  assign answer_byte_o = byte_r;

  no_early_answer_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    answer_start_o |-> $past(state_r) == ST_WAIT)
    else $error("Answer started before the write finished.");

  exec_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (state_r == ST_EXEC && exec_cnt_r > 32'd1) |=> (state_r == ST_EXEC && !answer_start_o))
    else $error("Write timer left before it ran out.");

  slot_taken_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (state_r == ST_WAIT && !opt_r && slot_hit) |=> answer_start_o)
    else $error("Flag-clear answer missed the first slot after the write.");

  slot_answer_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (answer_start_o && !opt_r) |-> $past(slot_hit))
    else $error("Flag-clear answer outside a response slot.");

  eof_answer_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (answer_start_o && opt_r) |-> $past(eof_rise))
    else $error("Flag-set answer not on a reader EOF.");

  block_exec_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (state_r == ST_IDLE && start_i && req_i.block_kind && !req_i.coding_256)
      |=> exec_cnt_r == BLOCK_4_CYC)
    else $error("Block write time loaded wrongly.");

  block_long_exec_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (state_r == ST_IDLE && start_i && req_i.block_kind && req_i.coding_256)
      |=> exec_cnt_r == BLOCK_256_CYC)
    else $error("Block write time for the slow coding loaded wrongly.");

  other_exec_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (state_r == ST_IDLE && start_i && !req_i.block_kind && req_i.coding_256)
      |=> exec_cnt_r == OTHER_256_CYC)
    else $error("Other write time loaded wrongly.");

  other_short_exec_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (state_r == ST_IDLE && start_i && !req_i.block_kind && !req_i.coding_256)
      |=> exec_cnt_r == OTHER_4_CYC)
    else $error("Other write time for the fast coding loaded wrongly.");

  byte_keep_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (state_r == ST_IDLE && start_i) |=> answer_byte_o == $past(answer_byte_i))
    else $error("Answer byte not kept.");

  refused_keep_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (state_r != ST_IDLE && start_i) |=> ($stable(answer_byte_o) && $stable(opt_r)))
    else $error("A command during a write disturbed the running one.");
endmodule // nvm_write_response_timing

// ---- sim/reader_model.sv ----
`timescale 1ns/10ps
// Reader side: field carrier that runs free, and end-of-frame marks.
module reader_model (
  input wire logic clk_sys_i,
  output logic carrier_clk_o,
  output logic eof_o
);
  initial begin
    carrier_clk_o = 1'b0;
    eof_o = 1'b0;
    #3;
    forever #62.5 carrier_clk_o = ~carrier_clk_o;
  end
  // The mark is held three cycles so the two-stage sampler cannot miss it.
  task automatic send_eof();
    @(posedge clk_sys_i);
    eof_o <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    eof_o <= 1'b0;
  endtask
endmodule // reader_model

// ---- sim/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import nvm_resp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic carrier_clk_i;
  logic eof_i;
  logic start_i = 1'b0;
  write_req_type req_i = '0;
  logic [7:0] answer_byte_i = 8'h00;
  logic busy_o;
  logic answer_start_o;
  logic [7:0] answer_byte_o;
  int errors = 0;
  int compares = 0;
  int cycles = 0;
  int pulses = 0;
  realtime t0;
  always #5 clk_sys_i = ~clk_sys_i;
  reader_model reader_model_inst (.clk_sys_i(clk_sys_i), .carrier_clk_o(carrier_clk_i),
    .eof_o(eof_i));
  nvm_write_response_timing #(.BLOCK_4_CYC(50), .BLOCK_256_CYC(60), .OTHER_4_CYC(70),
    .OTHER_256_CYC(80)) nvm_write_response_timing_inst (.clk_sys_i(clk_sys_i),
    .reset_i(reset_i), .carrier_clk_i(carrier_clk_i), .eof_i(eof_i), .start_i(start_i),
    .req_i(req_i), .answer_byte_i(answer_byte_i), .busy_o(busy_o),
    .answer_start_o(answer_start_o), .answer_byte_o(answer_byte_o));
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (answer_start_o === 1'b1) pulses <= pulses + 1;
    if (cycles == 80000) begin
      $display("ERROR timeout expected %0d seen %0d", 80000, cycles);
      errors++;
      complete_run();
    end
  end
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic issue(write_req_type r, logic [7:0] b);
    @(posedge clk_sys_i);
    start_i <= 1'b1;
    req_i <= r;
    answer_byte_i <= b;
    t0 = $realtime;
    @(posedge clk_sys_i);
    start_i <= 1'b0;
  endtask
  // A second command during the write must be dropped, and an early mark ignored.
  task automatic test_flag_set(logic kind, logic c256, int exec);
    int p0;
    p0 = pulses;
    issue({kind, c256, 1'b1}, {kind, c256, 6'h2d});
    issue({kind, c256, 1'b0}, 8'h00);
    repeat (exec - 9) @(posedge clk_sys_i);
    reader_model_inst.send_eof();
    repeat (10) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("early answer", 8'(p0), 8'(pulses));
    check("busy held", 8'h01, {7'h00, busy_o});
    reader_model_inst.send_eof();
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("answer count", 8'(p0 + 1), 8'(pulses));
    check("busy freed", 8'h00, {7'h00, busy_o});
    check("answer byte", {kind, c256, 6'h2d}, answer_byte_o);
    $display("test flag_set %0d%0d done", kind, c256);
  endtask
  task automatic test_slot();
    realtime d;
    issue(3'b100, 8'h81);
    for (int i = 0; i < 60000 && answer_start_o !== 1'b1; i++) @(negedge clk_sys_i);
    d = $realtime - t0;
    check("slot time", 8'h01, {7'h00, d >= 540000.0 && d <= 548100.0});
    $display("test slot done");
  endtask
  // A reset in mid-write abandons the write, so no answer may follow it.
  task automatic test_reset();
    int p0;
    p0 = pulses;
    issue(3'b010, 8'h5a);
    repeat (5) @(posedge clk_sys_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("busy in reset", 8'h00, {7'h00, busy_o});
    check("byte in reset", 8'h00, answer_byte_o);
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (100) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("busy after reset", 8'h00, {7'h00, busy_o});
    check("answer after reset", 8'(p0), 8'(pulses));
    $display("test reset done");
  endtask
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    test_flag_set(1'b1, 1'b0, 50);
    test_flag_set(1'b1, 1'b1, 60);
    test_flag_set(1'b0, 1'b0, 70);
    test_flag_set(1'b0, 1'b1, 80);
    test_reset();
    test_slot();
    complete_run();
  end
endmodule // testbench
